// ---- verilog/interleaved_backplane_mux.sv ----
// Purpose: Interleaved backplane multiplexer for eight framer ports.
// Assumes: 100 MHz i_clk; backplane clocks, syncs and pins sampled by two flip-flops.
// Notes: Backplane pin and channel block outputs change only on sampled backplane clock rising edges.
// How it works
// RULE_01 - Ganged: pins tri-state outside own slots.
// RULE_02 - Internal: merged stream on lowest group pin.
// RULE_03 - Gang select bit picks the mode.
// RULE_04 - Channel blocks timed by system clocks.
// RULE_05 - Gang control register at 00F0h.
// RULE_06 - Bus config register sets ports and speed.
// RULE_07 - Per-port rx and tx interleave registers.
// RULE_08 - Port n registers at stride 200h.
// RULE_09 - Rx data pins grouped per rate.
// RULE_10 - Rx signaling follows rx data grouping.
// RULE_11 - Tx data demultiplexed from group pins.
// RULE_12 - Tx signaling enters on same pins.
// RULE_13 - Lowest group sync pin serves group.
// RULE_14 - Ports take ascending slots, channel or frame.
// RULE_15 - Bus rate is 2.048 MHz times ports.
`default_nettype none
`include "backplane_consts.svh"
module interleaved_backplane_mux (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  // Port side receive bytes, port n in bits 8n+7..8n
  input wire logic [63:0] i_port_rx_data,
  input wire logic [63:0] i_port_rx_sig,
  output logic [7:0] o_port_rx_take,
  // Port side transmit bytes
  output logic o_port_tx_valid,
  output logic [2:0] o_port_tx_port,
  output logic [7:0] o_port_tx_data,
  output logic [7:0] o_port_tx_sig,
  input wire logic i_port_tx_ready,
  // Backplane clocks and syncs
  input wire logic i_rx_system_clock,
  input wire logic i_tx_system_clock,
  input wire logic [7:0] i_rx_frame_sync,
  input wire logic i_tx_frame_sync,
  // Backplane receive pins
  output logic [7:0] o_rx_serial_data,
  output logic [7:0] o_rx_serial_data_oe,
  output logic [7:0] o_rx_signaling_out,
  output logic [7:0] o_rx_signaling_out_oe,
  // Backplane transmit pins
  input wire logic [7:0] i_tx_serial_data,
  input wire logic [7:0] i_tx_signaling_in,
  // Channel block outputs
  output logic [7:0] o_rx_channel_block,
  output logic [7:0] o_tx_channel_block
);
  logic [26:0] s1_q, s2_q;
  logic rxclk_prev_q, txclk_prev_q, rx_upd_q, tx_upd_q;
  logic rx_edge, tx_edge, gang, interleaved_bus_operation;
  logic [7:0] rsync, tdat, tsig;
  logic tsync;
  logic [2:0] m;
  logic [10:0] last;
  backplane_pkg::rate_type rate;

  // Pin synchronisers; only the second stage is read.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      rxclk_prev_q <= 1'b0;
      txclk_prev_q <= 1'b0;
      rx_upd_q <= 1'b0;
      tx_upd_q <= 1'b0;
    end
    else
    begin
      s1_q <= {i_rx_system_clock, i_tx_system_clock, i_tx_frame_sync, i_rx_frame_sync,
               i_tx_serial_data, i_tx_signaling_in};
      s2_q <= s1_q;
      rxclk_prev_q <= s2_q[26];
      txclk_prev_q <= s2_q[25];
      rx_upd_q <= rx_edge;
      tx_upd_q <= tx_edge;
    end
  end

  assign rx_edge = s2_q[26] && !rxclk_prev_q;
  assign tx_edge = s2_q[25] && !txclk_prev_q;
  assign tsync = s2_q[24];
  assign rsync = s2_q[23:16];
  assign tdat = s2_q[15:8];
  assign tsig = s2_q[7:0];

  // Registers.
  logic [7:0] gctl_q, gctl_d, bcfg_q, bcfg_d, rd_q, rd_d;
  logic [7:0] rxc_q [8];
  logic [7:0] rxc_d [8];
  logic [7:0] txc_q [8];
  logic [7:0] txc_d [8];
  logic ovr_q, ovr_d, ovr_set;
  logic [2:0] aport;
  logic rx_hit, tx_hit;

  assign aport = i_addr[11:`PORT_FIELD_LSB];
  assign rx_hit = i_addr[`PORT_FIELD_LSB-1:0] == `RX_IL_OFFSET; // RULE_08
  assign tx_hit = i_addr[`PORT_FIELD_LSB-1:0] == `TX_IL_OFFSET; // RULE_08
  assign gang = gctl_q[`GANG_BIT]; // RULE_03
  assign rate = backplane_pkg::rate_type'(bcfg_q[`RATE_LSB+1:`RATE_LSB]); // RULE_06
  assign interleaved_bus_operation = rate != backplane_pkg::RATE_2M;
  assign m = 3'((4'h1 << rate) - 4'h1); // RULE_15
  assign last = 11'((`FRAME_BITS << rate) - 12'h1); // RULE_15

  always_comb
  begin
    gctl_d = gctl_q;
    bcfg_d = bcfg_q;
    rxc_d = rxc_q;
    txc_d = txc_q;
    ovr_d = ovr_q;
    rd_d = 8'h00;
    if (i_wr)
    begin
      if (i_addr == `GANG_CTRL_ADDR)
        gctl_d = i_wr_data; // RULE_05
      if (i_addr == `BUS_CFG_ADDR)
        bcfg_d = i_wr_data; // RULE_06
      if (rx_hit)
        rxc_d[aport] = i_wr_data; // RULE_07
      if (tx_hit)
        txc_d[aport] = i_wr_data; // RULE_07
      if (i_addr == `STATUS_ADDR && i_wr_data[`OVR_BIT])
        ovr_d = 1'b0;
    end
    if (ovr_set)
      ovr_d = 1'b1;
    if (i_rd)
    begin
      if (i_addr == `GANG_CTRL_ADDR)
        rd_d = gctl_q;
      else if (i_addr == `BUS_CFG_ADDR)
        rd_d = bcfg_q;
      else if (i_addr == `STATUS_ADDR)
        rd_d = {7'h00, ovr_q};
      else if (rx_hit)
        rd_d = rxc_q[aport];
      else if (tx_hit)
        rd_d = txc_q[aport];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      gctl_q <= `REG_RESET;
      bcfg_q <= `REG_RESET;
      rxc_q <= '{default: `REG_RESET};
      txc_q <= '{default: `REG_RESET};
      ovr_q <= 1'b0;
      rd_q <= 8'h00;
    end
    else
    begin
      gctl_q <= gctl_d;
      bcfg_q <= bcfg_d;
      rxc_q <= rxc_d;
      txc_q <= txc_d;
      ovr_q <= ovr_d;
      rd_q <= rd_d;
    end
  end

  assign o_rd_data = rd_q;

  // Port within the group for slot count c.
  function automatic logic [2:0] slot_sel(input logic [10:0] c, input logic fm, input logic [2:0] mk);
    return (fm ? c[10:8] : c[5:3]) & mk; // RULE_14
  endfunction : slot_sel

  // Receive multiplexer.
  logic [10:0] rcnt_q [8];
  logic [10:0] rcnt_d [8];
  logic [7:0] rser_q, rser_d, rsoe_q, rsoe_d, rsig_q, rsig_d, rgoe_q, rgoe_d;
  logic [7:0] rblk_q, rblk_d, take_q, take_d;

  always_comb
  begin
    logic [2:0] g, prt, bt;
    logic [10:0] c;
    logic act, own;
    g = 3'h0;
    prt = 3'h0;
    bt = 3'h0;
    c = 11'h000;
    act = 1'b0;
    own = 1'b0;
    rcnt_d = rcnt_q;
    rser_d = rser_q;
    rsoe_d = rsoe_q;
    rsig_d = rsig_q;
    rgoe_d = rgoe_q;
    rblk_d = rblk_q;
    take_d = 8'h00;
    if (rx_edge)
    begin
      for (int p = 0; p < 8; p++)
      begin
        if (rsync[p])
          rcnt_d[p] = 11'h000; // RULE_13
        else if (rcnt_q[p] == last)
          rcnt_d[p] = 11'h000;
        else
          rcnt_d[p] = rcnt_q[p] + 11'h001;
      end
      for (int p = 0; p < 8; p++)
      begin
        g = 3'(p) & ~m;
        c = rcnt_d[g]; // RULE_13
        prt = g | slot_sel(c, rxc_q[g][`IL_FRAME_BIT], m); // RULE_14
        bt = c[2:0];
        act = !interleaved_bus_operation || rxc_q[prt][`IL_EN_BIT];
        own = prt == 3'(p);
        rser_d[p] = act ? i_port_rx_data[{prt, ~bt}] : 1'b1; // RULE_02
        rsig_d[p] = act ? i_port_rx_sig[{prt, ~bt}] : 1'b1; // RULE_10
        if (!interleaved_bus_operation)
          rsoe_d[p] = 1'b1;
        else if (gang)
          rsoe_d[p] = own && act; // RULE_01
        else
          rsoe_d[p] = g == 3'(p); // RULE_09
        rgoe_d[p] = rsoe_d[p]; // RULE_10
        rblk_d[p] = interleaved_bus_operation && own && rxc_q[p][`IL_EN_BIT]; // RULE_04
        take_d[p] = own && act && bt == 3'h7;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rcnt_q <= '{default: `CNT_RESET};
      rser_q <= 8'hff;
      rsoe_q <= 8'h00;
      rsig_q <= 8'hff;
      rgoe_q <= 8'h00;
      rblk_q <= 8'h00;
      take_q <= 8'h00;
    end
    else
    begin
      rcnt_q <= rcnt_d;
      rser_q <= rser_d;
      rsoe_q <= rsoe_d;
      rsig_q <= rsig_d;
      rgoe_q <= rgoe_d;
      rblk_q <= rblk_d;
      take_q <= take_d;
    end
  end

  assign o_rx_serial_data = rser_q;
  assign o_rx_serial_data_oe = rsoe_q;
  assign o_rx_signaling_out = rsig_q;
  assign o_rx_signaling_out_oe = rgoe_q;
  assign o_rx_channel_block = rblk_q;
  assign o_port_rx_take = take_q;

  // Transmit demultiplexer; finished bytes wait in pend until the buffer takes them.
  logic [10:0] tcnt_q, tcnt_d;
  logic [7:0] tsh_q [8];
  logic [7:0] tsh_d [8];
  logic [7:0] tsg_q [8];
  logic [7:0] tsg_d [8];
  logic [7:0] wd_q [8];
  logic [7:0] wd_d [8];
  logic [7:0] ws_q [8];
  logic [7:0] ws_d [8];
  logic [7:0] pend_q, pend_d, tblk_q, tblk_d;
  logic [2:0] pidx;
  logic buf_ready;

  always_comb
  begin
    pidx = 3'h0;
    for (int q = 7; q >= 0; q--)
      if (pend_q[q])
        pidx = 3'(q);
  end

  always_comb
  begin
    logic [2:0] g, prt, src;
    logic act, own;
    g = 3'h0;
    prt = 3'h0;
    src = 3'h0;
    act = 1'b0;
    own = 1'b0;
    ovr_set = 1'b0;
    tcnt_d = tcnt_q;
    tsh_d = tsh_q;
    tsg_d = tsg_q;
    wd_d = wd_q;
    ws_d = ws_q;
    pend_d = pend_q;
    tblk_d = tblk_q;
    if (buf_ready && pend_q != 8'h00)
      pend_d[pidx] = 1'b0;
    if (tx_edge)
    begin
      tcnt_d = (tsync || tcnt_q == last) ? 11'h000 : tcnt_q + 11'h001;
      for (int q = 0; q < 8; q++)
      begin
        g = 3'(q) & ~m;
        prt = g | slot_sel(tcnt_d, txc_q[g][`IL_FRAME_BIT], m); // RULE_14
        own = prt == 3'(q);
        act = !interleaved_bus_operation || txc_q[q][`IL_EN_BIT];
        src = (gang && interleaved_bus_operation) ? 3'(q) : g; // RULE_11
        tblk_d[q] = interleaved_bus_operation && own && txc_q[q][`IL_EN_BIT]; // RULE_04
        if (own)
        begin
          tsh_d[q] = {tsh_q[q][6:0], tdat[src]}; // RULE_11
          tsg_d[q] = {tsg_q[q][6:0], tsig[src]}; // RULE_12
          if (act && tcnt_d[2:0] == 3'h7)
          begin
            ovr_set = ovr_set || pend_d[q];
            pend_d[q] = 1'b1;
            wd_d[q] = tsh_d[q];
            ws_d[q] = tsg_d[q];
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tcnt_q <= `CNT_RESET;
      tsh_q <= '{default: 8'h00};
      tsg_q <= '{default: 8'h00};
      wd_q <= '{default: 8'h00};
      ws_q <= '{default: 8'h00};
      pend_q <= 8'h00;
      tblk_q <= 8'h00;
    end
    else
    begin
      tcnt_q <= tcnt_d;
      tsh_q <= tsh_d;
      tsg_q <= tsg_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      pend_q <= pend_d;
      tblk_q <= tblk_d;
    end
  end

  assign o_tx_channel_block = tblk_q;

  pair_buffer #(.W(19)) u_tx_buffer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(pend_q != 8'h00),
    .i_data({pidx, wd_q[pidx], ws_q[pidx]}),
    .o_ready(buf_ready),
    .o_valid(o_port_tx_valid),
    .o_data({o_port_tx_port, o_port_tx_data, o_port_tx_sig}),
    .i_ready(i_port_tx_ready)
  );

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_gang_own;
    rx_upd_q && $past(gang) && $past(interleaved_bus_operation) |-> (o_rx_serial_data_oe & ~o_rx_channel_block) == 8'h00;
  endproperty
  a_gang_own: assert property (p_gang_own) else $error("Ganged pin driven outside its slot"); // RULE_01
  property p_gang_one;
    rx_upd_q && $past(gang) && $past(interleaved_bus_operation) |-> $countones(o_rx_serial_data_oe) <= int'(4'h8 >> $past(rate));
  endproperty
  a_gang_one: assert property (p_gang_one) else $error("More ganged pins driven than groups"); // RULE_03
  property p_mux16;
    rx_upd_q && !$past(gang) && $past(rate) == backplane_pkg::RATE_16M |-> o_rx_serial_data_oe == 8'h01;
  endproperty
  a_mux16: assert property (p_mux16) else $error("Merged stream not on pin one alone"); // RULE_02
  property p_mux4;
    rx_upd_q && !$past(gang) && $past(rate) == backplane_pkg::RATE_4M |-> o_rx_serial_data_oe == 8'h55;
  endproperty
  a_mux4: assert property (p_mux4) else $error("Wrong pins at the double rate"); // RULE_09
  property p_sig8;
    rx_upd_q && !$past(gang) && $past(rate) == backplane_pkg::RATE_8M |-> o_rx_signaling_out_oe == 8'h11;
  endproperty
  a_sig8: assert property (p_sig8) else $error("Signaling pins grouped wrongly"); // RULE_10
  property p_rblk;
    !rx_upd_q |-> $stable(o_rx_channel_block);
  endproperty
  a_rblk: assert property (p_rblk) else $error("Rx channel block moved off the rx clock"); // RULE_04
  property p_tblk;
    !tx_upd_q |-> $stable(o_tx_channel_block);
  endproperty
  a_tblk: assert property (p_tblk) else $error("Tx channel block moved off the tx clock"); // RULE_04
  property p_wrap;
    rx_edge && !rsync[0] && rate == backplane_pkg::RATE_16M |=> rcnt_q[0] == 11'($past(rcnt_q[0]) + 11'h001);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Frame count does not wrap at eight ports"); // RULE_15
  property p_stride;
    i_rd && i_addr == 12'h288 |=> o_rd_data == $past(rxc_q[1]);
  endproperty
  a_stride: assert property (p_stride) else $error("Port two register not at its stride"); // RULE_08
  property p_take;
    rx_upd_q && $past(rate) == backplane_pkg::RATE_16M |-> $onehot0(o_port_rx_take);
  endproperty
  a_take: assert property (p_take) else $error("Two ports share one slot"); // RULE_14
endmodule : interleaved_backplane_mux
`default_nettype wire

// ---- verilog/backplane_consts.svh ----
// Purpose: Offsets, field positions, reset values and counts for the backplane multiplexer.
// Assumes: Byte addresses on a 12-bit register port.
// Notes: Definitions only.
`ifndef BACKPLANE_CONSTS_SVH
`define BACKPLANE_CONSTS_SVH
`define GANG_CTRL_ADDR 12'h0f0
`define BUS_CFG_ADDR 12'h0f1
`define STATUS_ADDR 12'h0f2
`define RX_IL_OFFSET 9'h088
`define TX_IL_OFFSET 9'h188
`define PORT_FIELD_LSB 9
`define GANG_BIT 0
`define RATE_LSB 0
`define IL_EN_BIT 0
`define IL_FRAME_BIT 1
`define OVR_BIT 0
`define REG_RESET 8'h00
`define FRAME_BITS 12'h100
`define CNT_RESET 11'h7ff
`endif

// ---- verilog/backplane_pkg.sv ----
// Purpose: Types shared by the backplane multiplexer files.
// Assumes: Nothing.
// Notes: Bus rate code is the per-port rate times two to the code.
`default_nettype none
package backplane_pkg;
  typedef enum logic [1:0] {RATE_2M, RATE_4M, RATE_8M, RATE_16M} rate_type;
endpackage : backplane_pkg
`default_nettype wire

// ---- verilog/pair_buffer.sv ----
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock, synchronous reset.
// Notes: All outputs come from flip-flops.
`default_nettype none
module pair_buffer #(
  parameter int W = 19
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  logic [W-1:0] head_q, head_d, skid_q, skid_d;
  logic head_v_q, head_v_d, skid_v_q, skid_v_d;

  always_comb
  begin
    head_d = head_q;
    head_v_d = head_v_q;
    skid_d = skid_q;
    skid_v_d = skid_v_q;
    if (head_v_q && i_ready)
    begin
      head_d = skid_q;
      head_v_d = skid_v_q;
      skid_v_d = 1'b0;
    end
    if (i_valid && !skid_v_q)
    begin
      if (!head_v_d)
      begin
        head_d = i_data;
        head_v_d = 1'b1;
      end
      else
      begin
        skid_d = i_data;
        skid_v_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      head_q <= '0;
      skid_q <= '0;
      head_v_q <= 1'b0;
      skid_v_q <= 1'b0;
    end
    else
    begin
      head_q <= head_d;
      skid_q <= skid_d;
      head_v_q <= head_v_d;
      skid_v_q <= skid_v_d;
    end
  end

  assign o_valid = head_v_q;
  assign o_data = head_q;
  assign o_ready = !skid_v_q;
endmodule : pair_buffer
`default_nettype wire

// ---- sim/backplane_partner.sv ----
// Purpose: Backplane bus model that clocks one 40-bit frame on request.
// Assumes: Link clock of 125 ns that stands still between frames.
// Notes: Pins 0 and 1 are captured as one ganged wire.
`default_nettype none
module backplane_partner (
  // Bench control
  input wire logic i_start,
  input wire logic [15:0] i_tx_word,
  output logic o_done,
  output logic [15:0] o_rx_cap,
  output logic [15:0] o_sig_cap,
  output logic [7:0] o_oe_cap,
  // Backplane
  output logic o_link_clk,
  output logic [7:0] o_sync,
  output logic [7:0] o_tx_ser,
  output logic [7:0] o_tx_sig,
  input wire logic [7:0] i_rx_ser,
  input wire logic [7:0] i_rx_ser_oe,
  input wire logic [7:0] i_rx_sig,
  input wire logic [7:0] i_rx_sig_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic b;
  initial
  begin
    o_done = 1'b0;
    o_link_clk = 1'b0;
    o_sync = 8'h00;
    o_tx_ser = 8'h00;
    o_tx_sig = 8'hff;
  end
  always
  begin
    wait (i_start === 1'b1);
    #3;
    o_rx_cap = 16'h0000;
    o_sig_cap = 16'h0000;
    o_oe_cap = 8'h00;
    for (int k = 0; k < 40; k++)
    begin
      b = (k < 16) ? i_tx_word[15 - k] : k[0];
      // Pin 1 carries the inverse so that taking it by mistake shows.
      o_tx_ser = {{7{~b}}, b};
      o_tx_sig = ~o_tx_ser;
      o_sync = {8{k == 0}};
      #62.5;
      o_link_clk = 1'b1;
      #62.5;
      o_link_clk = 1'b0;
      if (k < 16)
      begin
        o_rx_cap = {o_rx_cap[14:0], i_rx_ser_oe[0] ? i_rx_ser[0] : i_rx_ser_oe[1] ? i_rx_ser[1] : ~o_rx_cap[0]};
        o_sig_cap = {o_sig_cap[14:0], i_rx_sig_oe[0] ? i_rx_sig[0] : i_rx_sig_oe[1] ? i_rx_sig[1] : ~o_sig_cap[0]};
        o_oe_cap = o_oe_cap | i_rx_ser_oe;
      end
    end
    o_sync = 8'h00;
    o_tx_ser = ~o_tx_ser;
    o_tx_sig = ~o_tx_sig;
    o_done = 1'b1;
    wait (i_start === 1'b0);
    o_done = 1'b0;
  end
endmodule : backplane_partner
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for the interleaved backplane multiplexer.
// Assumes: The partner clocks one 40-bit frame per request.
// Notes: Each row sets gang, rate and frame mode, then checks pin 0 and 1.
`default_nettype none
`include "backplane_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // Row: gang, rate, frame, captured data, enables seen, channel blocks.
  localparam logic [35:0] rows_c [7] = '{36'h0a5a5ff00, 36'h2a53c5555, 36'h4a53c1111, 36'h6a53c0110,
    36'h7a5a50101, 36'hea53c0310, 36'haa53cff55};
  localparam logic [18:0] tx_exp_c [4] = '{19'h0c33c, 19'h15aa5, 19'h055aa, 19'h155aa};
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_port_tx_ready = 1'b1;
  logic start = 1'b0;
  logic [63:0] rx_bytes = 64'h0102030405063ca5;
  logic [7:0] o_rd_data, o_port_rx_take, o_port_tx_data, o_port_tx_sig, o_rx_serial_data, o_rx_serial_data_oe;
  logic [7:0] o_rx_signaling_out, o_rx_signaling_out_oe, o_rx_channel_block, o_tx_channel_block;
  logic [7:0] sync, tx_ser, tx_sig, oe_cap;
  logic [2:0] o_port_tx_port;
  logic [15:0] cap, sig_cap;
  logic o_port_tx_valid, done, link_clk;
  logic [35:0] row;
  logic [18:0] got_q [$];
  int fail_count = 0;
  int check_count = 0;
  int take_count = 0;
  int take_base = 0;

  interleaved_backplane_mux i_interleaved_backplane_mux (.i_clk, .i_rst, .i_addr, .i_wr_data, .i_wr, .i_rd,
    .o_rd_data, .i_port_rx_data(rx_bytes), .i_port_rx_sig(~rx_bytes), .o_port_rx_take, .o_port_tx_valid,
    .o_port_tx_port, .o_port_tx_data, .o_port_tx_sig, .i_port_tx_ready, .i_rx_system_clock(link_clk),
    .i_tx_system_clock(link_clk), .i_rx_frame_sync(sync), .i_tx_frame_sync(sync[0]), .o_rx_serial_data,
    .o_rx_serial_data_oe, .o_rx_signaling_out, .o_rx_signaling_out_oe, .i_tx_serial_data(tx_ser),
    .i_tx_signaling_in(tx_sig), .o_rx_channel_block, .o_tx_channel_block);
  backplane_partner i_backplane_partner (.i_start(start), .i_tx_word(16'hc35a), .o_done(done),
    .o_rx_cap(cap), .o_sig_cap(sig_cap), .o_oe_cap(oe_cap), .o_link_clk(link_clk), .o_sync(sync),
    .o_tx_ser(tx_ser), .o_tx_sig(tx_sig), .i_rx_ser(o_rx_serial_data), .i_rx_ser_oe(o_rx_serial_data_oe),
    .i_rx_sig(o_rx_signaling_out), .i_rx_sig_oe(o_rx_signaling_out_oe));

  always #5 i_clk = ~i_clk;
  always @(negedge i_clk)
  begin
    if (o_port_tx_valid === 1'b1 && i_port_tx_ready === 1'b1)
      got_q.push_back({o_port_tx_port, o_port_tx_data, o_port_tx_sig});
    take_count = take_count + $countones(o_port_rx_take);
  end

  task automatic chk(input logic [18:0] got, input logic [18:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(19'(o_rd_data), 19'(e), "read data");
    @(posedge i_clk);
  endtask : rd_chk

  task automatic run_frame();
    start <= 1'b1;
    for (int w = 0; w < 1000 && done !== 1'b1; w++)
      @(posedge i_clk);
    chk(19'(done), 19'h00001, "frame end");
    start <= 1'b0;
    repeat (10) @(posedge i_clk);
  endtask : run_frame

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial
  begin
    #300000;
    fail_count++;
    $display("MISMATCH at %0t: run did not finish", $time);
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd_chk(`GANG_CTRL_ADDR, `REG_RESET);
    rd_chk(`BUS_CFG_ADDR, `REG_RESET);
    for (int n = 0; n < 8; n++)
    begin
      rd_chk({n[2:0], `RX_IL_OFFSET}, `REG_RESET);
      rd_chk({n[2:0], `TX_IL_OFFSET}, `REG_RESET);
      wr({n[2:0], `RX_IL_OFFSET}, 8'h90 + 8'(n));
      wr({n[2:0], `TX_IL_OFFSET}, 8'he0 + 8'(n));
    end
    wr(12'h089, 8'hff);
    wr(`BUS_CFG_ADDR, 8'hfc);
    for (int n = 0; n < 8; n++)
    begin
      rd_chk({n[2:0], `RX_IL_OFFSET}, 8'h90 + 8'(n));
      rd_chk({n[2:0], `TX_IL_OFFSET}, 8'he0 + 8'(n));
    end
    rd_chk(12'h089, 8'h00);
    rd_chk(`BUS_CFG_ADDR, 8'hfc);
    $display("register test done");
    for (int r = 0; r < 7; r++)
    begin
      row = rows_c[r];
      wr(`GANG_CTRL_ADDR, {7'h00, row[35]});
      wr(`BUS_CFG_ADDR, {6'h00, row[34:33]});
      for (int n = 0; n < 8; n++)
      begin
        wr({n[2:0], `RX_IL_OFFSET}, {6'h00, row[32], 1'b1});
        wr({n[2:0], `TX_IL_OFFSET}, 8'h00);
      end
      take_base = take_count;
      run_frame();
      chk(19'(cap), 19'(row[31:16]), "rx data");
      chk(19'(sig_cap), 19'({~row[31:16]}), "rx signaling");
      chk(19'(take_count - take_base), 19'(8'h28 >> row[34:33]), "rx byte takes");
      chk(19'(oe_cap), 19'(row[15:8]), "rx pin enables");
      chk(19'(o_rx_channel_block), 19'(row[7:0]), "rx channel block");
      $display("rx row %0d done", r);
    end
    wr(`GANG_CTRL_ADDR, 8'h00);
    wr(`BUS_CFG_ADDR, 8'h01);
    for (int n = 0; n < 8; n++)
      wr({n[2:0], `TX_IL_OFFSET}, {7'h00, n < 2});
    got_q.delete();
    i_port_tx_ready <= 1'b0;
    run_frame();
    chk(19'(o_port_tx_valid), 19'h00001, "tx word stands");
    chk(19'(o_tx_channel_block), 19'h00001, "tx channel block");
    rd_chk(`STATUS_ADDR, 8'h01);
    i_port_tx_ready <= 1'b1;
    for (int w = 0; w < 100 && got_q.size() < 4; w++)
      @(posedge i_clk);
    repeat (10) @(posedge i_clk);
    chk(19'(got_q.size()), 19'h00004, "tx word count");
    for (int k = 0; k < 4 && k < got_q.size(); k++)
      chk(got_q[k], tx_exp_c[k], "tx word");
    wr(`STATUS_ADDR, 8'h01);
    rd_chk(`STATUS_ADDR, 8'h00);
    $display("tx test done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
